// [dpwc_device.sv]
// Potentiometer control and memory: wiper register, data registers,
// tap decode, three-wire step logic and a serial instruction engine.
// Assumes link pins come from another party and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module dpwc_device
   import dpwc_pkg::*;
#(
   parameter logic [1:0] VARIANT     = IF_SPI,
   parameter int         NPOT        = NPOT_DEF,
   parameter int         WIPER_W     = WIPER_W_DEF,
   parameter int         NV_WRITE_N  = NV_WRITE_CYC
) (
   input  wire logic                          REF_CLK,
   input  wire logic                          RST_N,
   dpwc_link_if.dev                           LINK,
   output logic [NPOT-1:0][(2**WIPER_W)-1:0]  TAP_SEL,
   output logic [NPOT-1:0][WIPER_W-1:0]       WIPER_POS,
   output logic                               NV_BUSY
);

   // ------------------------------------------------------------------
   // Types and constants
   // ------------------------------------------------------------------
   localparam int TAPS   = 2 ** WIPER_W;
   localparam int BUSY_W = $clog2(NV_WRITE_N + 1);
   localparam logic [WIPER_W-1:0] WIPER_TOP = {WIPER_W{1'b1}};
   localparam logic [TAPS-1:0]    TAP_ZERO  = {{(TAPS-1){1'b0}}, 1'b1};

   typedef enum logic [0:0] {
      DS_RECALL = 1'b0,
      DS_READY  = 1'b1
   } dpwc_dev_state_t;

   typedef struct packed {
      dpwc_dev_state_t                         state;
      logic [2:0]                              sck_s;
      logic [2:0]                              cs_s;
      logic [2:0]                              si_s;
      logic [2:0]                              up_s;
      logic [2:0]                              step_s;
      logic [2:0]                              sel_s;
      logic [4:0]                              bit_cnt;
      logic [DATA_W-1:0]                       instr;
      logic [DATA_W-1:0]                       shin;
      logic [DATA_W-1:0]                       so_sh;
      logic [NPOT-1:0][WIPER_W-1:0]            wiper;
      logic [NPOT-1:0][NREG-1:0][DATA_W-1:0]   dr;
      logic [BUSY_W-1:0]                       busy_cnt;
      logic [NPOT-1:0][TAPS-1:0]               tap;
   } dpwc_dev_st_t;

   dpwc_dev_st_t q;
   dpwc_dev_st_t d;

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------

   // One tap up or down, held at the end taps
   function automatic logic [WIPER_W-1:0] step_w(input logic [WIPER_W-1:0] w,
                                                 input logic up);
      if (up) begin
         step_w = (w == WIPER_TOP) ? w : w + 1'b1;
      end else begin
         step_w = (w == '0) ? w : w - 1'b1;
      end
   endfunction

   // Wiper position to one-hot tap switch select
   function automatic logic [TAPS-1:0] onehot(input logic [WIPER_W-1:0] w);
      onehot = TAP_ZERO << w;
   endfunction

   // Pot index present on this device
   function automatic logic pot_ok(input logic [1:0] p);
      pot_ok = (int'(p) < NPOT);
   endfunction

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] rx;
   logic [DATA_W-1:0] rd;
   logic [3:0]        op;
   logic [1:0]        pi;
   logic [1:0]        ri;
   logic [3:0]        rop;
   logic [1:0]        rpi;
   logic [1:0]        rri;
   logic              nvw_ok;
   logic              sck_rise;
   logic              sck_fall;
   logic              step_fall;

   always_comb begin
      rx        = {q.shin[DATA_W-2:0], q.si_s[1]};
      op        = q.instr[OP_MSB:OP_LSB];
      pi        = q.instr[POT_MSB:POT_LSB];
      ri        = q.instr[REG_MSB:REG_LSB];
      rop       = rx[OP_MSB:OP_LSB];
      rpi       = rx[POT_MSB:POT_LSB];
      rri       = rx[REG_MSB:REG_LSB];
      nvw_ok    = (q.busy_cnt == '0);
      sck_rise  = q.sck_s[1] & ~q.sck_s[2];
      sck_fall  = ~q.sck_s[1] & q.sck_s[2];
      step_fall = ~q.step_s[1] & q.step_s[2];
      d         = q;

      // Two-stage synchronisers, third stage holds the previous level
      d.sck_s  = {q.sck_s[1:0], LINK.sck};
      d.cs_s   = {q.cs_s[1:0], LINK.cs_n};
      d.si_s   = {q.si_s[1:0], LINK.si};
      d.up_s   = {q.up_s[1:0], LINK.up_dn};
      d.step_s = {q.step_s[1:0], LINK.step};
      d.sel_s  = {q.sel_s[1:0], LINK.sel_n};

      // Nonvolatile write timer
      if (!nvw_ok) begin
         d.busy_cnt = q.busy_cnt - 1'b1;
      end

      // Answer prepared at the end of the instruction byte
      rd = '0;
      if (pot_ok(rpi)) begin
         case (rop)
            OP_RD_WPR:  rd = DATA_W'(q.wiper[rpi]);
            OP_RD_DR:   rd = q.dr[rpi][rri];
            OP_RD_BUSY: rd = {{(DATA_W-1){1'b0}}, ~nvw_ok};
            default:    rd = '0;
         endcase
      end

      case (q.state)
         // Power-up recall of stored wiper settings
         DS_RECALL: begin
            for (int p = 0; p < NPOT; p++) begin
               d.wiper[p] = q.dr[p][0][WIPER_W-1:0];
            end
            d.state = DS_READY;
         end
         DS_READY: begin
            if (VARIANT == IF_THREE_WIRE) begin
               // Steps only while selected, direction sampled at the edge
               if (!q.sel_s[1] && step_fall) begin
                  d.wiper[0] = step_w(q.wiper[0], q.up_s[1]);
               end
            end else if (q.cs_s[1]) begin
               d.bit_cnt = '0;
            end else if (sck_rise) begin
               d.shin    = rx;
               d.bit_cnt = q.bit_cnt + 5'h01;
               if (q.bit_cnt == BIT_INSTR_LAST) begin
                  d.instr = rx;
                  d.so_sh = rd;
               end else if (q.bit_cnt == BIT_FRAME_LAST && pot_ok(pi)) begin
                  case (op)
                     OP_WR_WPR: begin
                        d.wiper[pi] = rx[WIPER_W-1:0];
                     end
                     OP_WR_DR: begin
                        if (nvw_ok) begin
                           d.dr[pi][ri] = rx;
                           d.busy_cnt   = BUSY_W'(NV_WRITE_N);
                        end
                     end
                     OP_XFR_DR_WPR: begin
                        d.wiper[pi] = q.dr[pi][ri][WIPER_W-1:0];
                     end
                     OP_XFR_WPR_DR: begin
                        if (nvw_ok) begin
                           d.dr[pi][ri] = DATA_W'(q.wiper[pi]);
                           d.busy_cnt   = BUSY_W'(NV_WRITE_N);
                        end
                     end
                     OP_GXFR_DR_WPR: begin
                        for (int p = 0; p < NPOT; p++) begin
                           d.wiper[p] = q.dr[p][ri][WIPER_W-1:0];
                        end
                     end
                     OP_GXFR_WPR_DR: begin
                        if (nvw_ok) begin
                           for (int p = 0; p < NPOT; p++) begin
                              d.dr[p][ri] = DATA_W'(q.wiper[p]);
                           end
                           d.busy_cnt = BUSY_W'(NV_WRITE_N);
                        end
                     end
                     OP_INC:  d.wiper[pi] = step_w(q.wiper[pi], 1'b1);
                     OP_DEC:  d.wiper[pi] = step_w(q.wiper[pi], 1'b0);
                     default: d.wiper[pi] = q.wiper[pi];
                  endcase
               end
            end else if (sck_fall && q.bit_cnt > BIT_INSTR_LAST + 5'h01) begin
               // Answer bits leave on falling edges after the first
               d.so_sh = {q.so_sh[DATA_W-2:0], 1'b0};
            end
         end
         default: d.state = DS_RECALL;
      endcase

      // Tap switches follow the wiper register
      for (int p = 0; p < NPOT; p++) begin
         d.tap[p] = onehot(d.wiper[p]);
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         q        <= '0;
         q.state  <= DS_RECALL;
         q.cs_s   <= SYNC_HI;
         q.step_s <= SYNC_HI;
         q.sel_s  <= SYNC_HI;
         q.sck_s  <= SYNC_LO;
         for (int p = 0; p < NPOT; p++) begin
            q.tap[p] <= TAP_ZERO;
            for (int r = 0; r < NREG; r++) begin
               q.dr[p][r] <= NV_INIT;
            end
         end
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign LINK.so    = q.so_sh[DATA_W-1];
   assign LINK.so_oe = (VARIANT != IF_THREE_WIRE) & ~q.cs_s[1];
   assign TAP_SEL    = q.tap;
   assign WIPER_POS  = q.wiper;
   assign NV_BUSY    = ~nvw_ok;

endmodule // dpwc_device

`default_nettype wire

// [dpwc_pkg.sv]
// Shared constants for the digital potentiometer wiper control link.
// Assumes both ends run on one 125 MHz reference clock.
`default_nettype none

package dpwc_pkg;

   // ------------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------------
   localparam int NPOT_DEF    = 2;       // Potentiometers per device
   localparam int WIPER_W_DEF = 6;       // Wiper position width
   localparam int NREG        = 4;       // Data registers per pot
   localparam int DATA_W      = 8;       // Data register width

   // ------------------------------------------------------------------
   // Interface variants
   // ------------------------------------------------------------------
   localparam logic [1:0] IF_THREE_WIRE = 2'h0;
   localparam logic [1:0] IF_TWO_WIRE   = 2'h1;
   localparam logic [1:0] IF_SPI        = 2'h2;

   // ------------------------------------------------------------------
   // Serial frame: instruction byte then data byte, MSB first
   // ------------------------------------------------------------------
   localparam int         FRAME_BITS     = 16;
   localparam logic [4:0] BIT_INSTR_LAST = 5'h07;  // Bit count at 8th rise
   localparam logic [4:0] BIT_FRAME_LAST = 5'h0f;  // Bit count at 16th rise
   localparam int         OP_MSB         = 7;
   localparam int         OP_LSB         = 4;
   localparam int         REG_MSB        = 3;
   localparam int         REG_LSB        = 2;
   localparam int         POT_MSB        = 1;
   localparam int         POT_LSB        = 0;

   // ------------------------------------------------------------------
   // Instruction codes
   // ------------------------------------------------------------------
   localparam logic [3:0] OP_RD_WPR      = 4'h0;  // Read wiper position
   localparam logic [3:0] OP_WR_WPR      = 4'h1;  // Write wiper position
   localparam logic [3:0] OP_RD_DR       = 4'h2;  // Read data register
   localparam logic [3:0] OP_WR_DR       = 4'h3;  // Write data register
   localparam logic [3:0] OP_XFR_DR_WPR  = 4'h4;  // Data reg to wiper
   localparam logic [3:0] OP_XFR_WPR_DR  = 4'h5;  // Wiper to data reg
   localparam logic [3:0] OP_GXFR_DR_WPR = 4'h6;  // All pots, data to wiper
   localparam logic [3:0] OP_GXFR_WPR_DR = 4'h7;  // All pots, wiper to data
   localparam logic [3:0] OP_INC         = 4'h8;  // Wiper one tap up
   localparam logic [3:0] OP_DEC         = 4'h9;  // Wiper one tap down
   localparam logic [3:0] OP_RD_BUSY     = 4'ha;  // Write busy query

   // ------------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------------
   localparam logic [DATA_W-1:0] NV_INIT  = 8'h20;   // Data register contents at reset
   localparam logic [2:0]        SYNC_HI  = 3'h7;
   localparam logic [2:0]        SYNC_LO  = 3'h0;
   localparam int CLK_PERIOD_NS = 8;
   localparam int NV_WRITE_NS   = 5000;              // Nonvolatile write time
   localparam int NV_WRITE_CYC  = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCK_HALF_DEF  = 16;                // Link clock half period, cycles
   localparam int STEP_HALF_DEF = 16;                // Step pulse phase length, cycles

endpackage

`default_nettype wire

// [dpwc_link_if.sv]
// Pin-level link between the potentiometer and its controller.
// Both ends share REF_CLK; the interface resolves the serial out wire.
`timescale 1ns/1ps
`default_nettype none

interface dpwc_link_if;
   logic sck;       // Serial clock from controller
   logic cs_n;      // Serial frame select, active low
   logic si;        // Serial data to device
   logic so;        // Serial data from device
   logic so_oe;     // Device drives so
   logic so_line;   // Resolved level, pulled high when undriven
   logic up_dn;     // Three-wire direction, high moves up
   logic step;      // Three-wire step, acts on falling edge
   logic sel_n;     // Three-wire select, active low

   // Pull-up on the shared serial out wire
   assign so_line = so_oe ? so : 1'b1;

   modport dev (input sck, cs_n, si, up_dn, step, sel_n, output so, so_oe);
   modport host (output sck, cs_n, si, up_dn, step, sel_n, input so_line);
endinterface

`default_nettype wire

// [dpwc_host.sv]
// Controller end: turns user requests into serial frames or
// three-wire step pulses. Assumes the device shares REF_CLK's rate.
`timescale 1ns/1ps
`default_nettype none

module dpwc_host
   import dpwc_pkg::*;
#(
   parameter logic [1:0] VARIANT   = IF_SPI,
   parameter int         SCK_HALF  = SCK_HALF_DEF,
   parameter int         STEP_HALF = STEP_HALF_DEF
) (
   input  wire logic          REF_CLK,
   input  wire logic          RST_N,
   dpwc_link_if.host          LINK,
   input  wire logic          REQ_VALID,
   output logic               REQ_READY,
   input  wire logic [3:0]    REQ_OP,
   input  wire logic [1:0]    REQ_REG,
   input  wire logic [1:0]    REQ_POT,
   input  wire logic [7:0]    REQ_DATA,
   output logic               RSP_VALID,
   output logic [7:0]         RSP_DATA,
   input  wire logic          STEP_VALID,
   output logic               STEP_READY,
   input  wire logic          STEP_UP
);

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   localparam int DIV_W = 8;

   typedef enum logic [2:0] {
      HS_IDLE    = 3'b000,
      HS_SHIFT   = 3'b001,
      HS_GAP     = 3'b011,
      HS_TW_HIGH = 3'b010,
      HS_TW_LOW  = 3'b110
   } dpwc_host_state_t;

   typedef struct packed {
      dpwc_host_state_t    state;
      logic [DIV_W-1:0]    div;
      logic [4:0]          bit_cnt;
      logic [15:0]         sh_out;
      logic [7:0]          sh_in;
      logic [1:0]          so_s;
      logic                sck;
      logic                cs_n;
      logic                up;
      logic                step;
      logic                sel_n;
      logic                rsp_valid;
      logic [7:0]          rsp_data;
   } dpwc_host_st_t;

   dpwc_host_st_t q;
   dpwc_host_st_t d;

   logic div_end_sck;
   logic div_end_step;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      div_end_sck  = (q.div == DIV_W'(SCK_HALF - 1));
      div_end_step = (q.div == DIV_W'(STEP_HALF - 1));
      d            = q;
      d.so_s       = {q.so_s[0], LINK.so_line};
      d.rsp_valid  = 1'b0;
      d.div        = q.div + 1'b1;
      case (q.state)
         HS_IDLE: begin
            d.div = '0;
            if (VARIANT == IF_THREE_WIRE) begin
               if (STEP_VALID) begin
                  d.sel_n = 1'b0;
                  d.up    = STEP_UP;
                  d.state = HS_TW_HIGH;
               end
            end else if (REQ_VALID) begin
               d.sh_out  = {REQ_OP, REQ_REG, REQ_POT, REQ_DATA};
               d.cs_n    = 1'b0;
               d.bit_cnt = '0;
               d.state   = HS_SHIFT;
            end
         end
         HS_SHIFT: begin
            if (div_end_sck) begin
               d.div = '0;
               if (!q.sck) begin
                  d.sck   = 1'b1;
                  d.sh_in = {q.sh_in[6:0], q.so_s[1]};
               end else begin
                  d.sck     = 1'b0;
                  d.sh_out  = {q.sh_out[14:0], 1'b0};
                  d.bit_cnt = q.bit_cnt + 5'h01;
                  if (q.bit_cnt == BIT_FRAME_LAST) begin
                     d.cs_n      = 1'b1;
                     d.rsp_valid = 1'b1;
                     d.rsp_data  = q.sh_in;
                     d.state     = HS_GAP;
                  end
               end
            end
         end
         HS_TW_HIGH: begin
            // Direction and select settle before the falling edge
            if (div_end_step) begin
               d.div   = '0;
               d.step  = 1'b0;
               d.state = HS_TW_LOW;
            end
         end
         HS_TW_LOW: begin
            if (div_end_step) begin
               d.div   = '0;
               d.step  = 1'b1;
               d.sel_n = 1'b1;
               d.state = HS_GAP;
            end
         end
         HS_GAP: begin
            if (div_end_sck) begin
               d.state = HS_IDLE;
            end
         end
         default: d.state = HS_IDLE;
      endcase
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         q       <= '0;
         q.state <= HS_IDLE;
         q.cs_n  <= 1'b1;
         q.step  <= 1'b1;
         q.sel_n <= 1'b1;
         q.up    <= 1'b1;
         q.so_s  <= 2'h3;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign LINK.sck    = q.sck;
   assign LINK.cs_n   = q.cs_n;
   assign LINK.si     = q.sh_out[15];
   assign LINK.up_dn  = q.up;
   assign LINK.step   = q.step;
   assign LINK.sel_n  = q.sel_n;
   assign REQ_READY   = (q.state == HS_IDLE) && (VARIANT != IF_THREE_WIRE);
   assign STEP_READY  = (q.state == HS_IDLE) && (VARIANT == IF_THREE_WIRE);
   assign RSP_VALID   = q.rsp_valid;
   assign RSP_DATA    = q.rsp_data;

endmodule // dpwc_host

`default_nettype wire

// [dpwc_link_checker.sv]
// Assertions on the serial link and the wiper outputs of one device.
// Assumes a single REF_CLK domain, with the host end driving the link.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Link and wiper checker
// ------------------------------------------------------------------
module dpwc_link_checker
   import dpwc_pkg::*;
#(
   parameter int NPOT       = NPOT_DEF,
   parameter int WIPER_W    = WIPER_W_DEF,
   parameter int NV_WRITE_N = NV_WRITE_CYC
) (
   input wire logic                              REF_CLK,
   input wire logic                              RST_N,
   input wire logic                              sck,
   input wire logic                              cs_n,
   input wire logic                              si,
   input wire logic                              so_oe,
   input wire logic [NPOT-1:0][(2**WIPER_W)-1:0] TAP_SEL,
   input wire logic [NPOT-1:0][WIPER_W-1:0]      WIPER_POS,
   input wire logic                              NV_BUSY
);
   int busy_cyc_q;

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   // Length of the current busy span
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) busy_cyc_q <= 0;
      else busy_cyc_q <= NV_BUSY ? busy_cyc_q + 1 : 0;
   end

   // Link framing, wiper outputs and write busy timing
   a_sck_idle_low: assert property (cs_n |-> !sck) else $error("sck moved outside a frame");
   a_si_held_high: assert property (sck && $past(sck) |-> $stable(si)) else $error("si moved, sck high");
   a_select_gap: assert property ($rose(cs_n) |-> cs_n [*3]) else $error("frame gap too short");
   a_out_en_on: assert property ($fell(cs_n) |-> ##[2:4] so_oe) else $error("so not driven in frame");
   a_out_en_off: assert property (cs_n [*5] |-> !so_oe) else $error("so driven between frames");
   a_tap_follows: assert property (TAP_SEL[0][WIPER_POS[0]] && $onehot(TAP_SEL[0])) else $error("tap off");
   a_tap_onehot: assert property ($onehot(TAP_SEL[NPOT-1])) else $error("tap not one-hot");
   a_busy_holds: assert property ($rose(NV_BUSY) |-> NV_BUSY [*8]) else $error("busy dropped early");
   a_busy_length: assert property ($fell(NV_BUSY) |-> busy_cyc_q == NV_WRITE_N) else $error("busy length");

   c_write_busy: cover property ($rose(NV_BUSY));
   c_frame: cover property ($fell(cs_n));
   c_wiper_top: cover property (WIPER_POS[0] == '1);
endmodule // dpwc_link_checker

`default_nettype wire

// [dpwc_bench.sv]
// Self-checking bench: a serial pair and a three-wire pair of ends.
// Assumes package, link interface, both ends and checker compiled first.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Bench top
// ------------------------------------------------------------------
module dpwc_bench
   import dpwc_pkg::*;
;
   localparam int NV_N = 1500;  // Outlasts a query frame so busy is seen
   logic                                       ref_clk = 1'b0;
   logic                                       rst_n = 1'b0;
   logic                                       req_valid = 1'b0;
   logic                                       step_valid = 1'b0;
   logic                                       step_up = 1'b0;
   logic                                       req_ready, rsp_valid, step_ready, busy_s;
   logic [3:0]                                 req_op = 4'h0;
   logic [1:0]                                 req_reg = 2'h0;
   logic [1:0]                                 req_pot = 2'h0;
   logic [7:0]                                 req_data = 8'h00;
   logic [7:0]                                 rsp_data, rd;
   logic [NPOT_DEF-1:0][(2**WIPER_W_DEF)-1:0] tap_s, tap_t;
   logic [NPOT_DEF-1:0][WIPER_W_DEF-1:0]      wpos_s, wpos_t;
   int                                         err_count = 0;
   int                                         n_compared = 0;
   int                                         cyc = 0;

   dpwc_link_if link_s ();
   dpwc_link_if link_t ();

   // Serial pair and three-wire pair share the user-side requests
   dpwc_device #(.VARIANT(IF_SPI), .NV_WRITE_N(NV_N)) u_dpwc_device (.REF_CLK(ref_clk), .RST_N(rst_n),
      .LINK(link_s), .TAP_SEL(tap_s), .WIPER_POS(wpos_s), .NV_BUSY(busy_s));
   dpwc_host #(.VARIANT(IF_SPI)) u_dpwc_host (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(link_s),
      .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_OP(req_op), .REQ_REG(req_reg), .REQ_POT(req_pot),
      .REQ_DATA(req_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .STEP_VALID(step_valid),
      .STEP_READY(), .STEP_UP(step_up));
   dpwc_device #(.VARIANT(IF_THREE_WIRE), .NV_WRITE_N(NV_N)) u_dpwc_device_tw (.REF_CLK(ref_clk),
      .RST_N(rst_n), .LINK(link_t), .TAP_SEL(tap_t), .WIPER_POS(wpos_t), .NV_BUSY());
   dpwc_host #(.VARIANT(IF_THREE_WIRE)) u_dpwc_host_tw (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(link_t),
      .REQ_VALID(req_valid), .REQ_READY(), .REQ_OP(req_op), .REQ_REG(req_reg), .REQ_POT(req_pot),
      .REQ_DATA(req_data), .RSP_VALID(), .RSP_DATA(), .STEP_VALID(step_valid),
      .STEP_READY(step_ready), .STEP_UP(step_up));
   dpwc_link_checker #(.NPOT(NPOT_DEF), .WIPER_W(WIPER_W_DEF), .NV_WRITE_N(NV_N)) u_dpwc_link_checker (
      .REF_CLK(ref_clk), .RST_N(rst_n), .sck(link_s.sck), .cs_n(link_s.cs_n), .si(link_s.si),
      .so_oe(link_s.so_oe), .TAP_SEL(tap_s), .WIPER_POS(wpos_s), .NV_BUSY(busy_s));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic end_sim;
      if (err_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One serial frame; the answer byte lands in rd
   task automatic xfer(input logic [3:0] op, input logic [1:0] rg, input logic [1:0] pt, input logic [7:0] d);
      req_valid <= 1'b1;
      {req_op, req_reg, req_pot, req_data} <= {op, rg, pt, d};
      @(posedge ref_clk);
      while (req_ready !== 1'b1) @(posedge ref_clk);
      req_valid <= 1'b0;
      while (rsp_valid !== 1'b1) @(posedge ref_clk);
      rd = rsp_data;
   endtask

   // One three-wire step, then time for the wiper to move
   task automatic stepit(input logic up);
      step_valid <= 1'b1;
      step_up <= up;
      @(posedge ref_clk);
      while (step_ready !== 1'b1) @(posedge ref_clk);
      step_valid <= 1'b0;
      repeat (2 * STEP_HALF_DEF + 8) @(posedge ref_clk);
   endtask

   // Waits rely on the cycle ceiling, so a hang ends in failure
   task automatic idle_wait;
      while (busy_s !== 1'b0) @(posedge ref_clk);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_recall;
      int r;
      chk({2'h0, wpos_s[0]}, NV_INIT);
      chk({2'h0, wpos_t[0]}, NV_INIT);
      for (r = 0; r < NREG; r++) begin
         xfer(OP_RD_DR, 2'(r), 2'h1, 8'h00);
         chk(rd, NV_INIT);
      end
   endtask

   task automatic t_wiper;
      xfer(OP_WR_WPR, 2'h0, 2'h0, 8'h3f);
      chk({2'h0, wpos_s[0]}, 8'h3f);
      xfer(OP_WR_WPR, 2'h0, 2'h2, 8'h00);
      chk({2'h0, wpos_s[0]}, 8'h3f);
      xfer(OP_RD_WPR, 2'h0, 2'h0, 8'h00);
      chk(rd, 8'h3f);
   endtask

   task automatic t_busy;
      xfer(OP_WR_DR, 2'h2, 2'h1, 8'ha5);
      xfer(OP_RD_BUSY, 2'h0, 2'h0, 8'h00);
      chk(rd, 8'h01);
      xfer(OP_WR_DR, 2'h3, 2'h1, 8'h5a);
      idle_wait();
      xfer(OP_RD_BUSY, 2'h0, 2'h0, 8'h00);
      chk(rd, 8'h00);
      xfer(OP_RD_DR, 2'h3, 2'h1, 8'h00);
      chk(rd, NV_INIT);
      xfer(OP_RD_DR, 2'h2, 2'h1, 8'h00);
      chk(rd, 8'ha5);
   endtask

   task automatic t_xfer;
      xfer(OP_GXFR_DR_WPR, 2'h2, 2'h0, 8'h00);
      chk({2'h0, wpos_s[0]}, NV_INIT);
      chk({2'h0, wpos_s[1]}, 8'h25);
      xfer(OP_WR_WPR, 2'h0, 2'h1, 8'h11);
      xfer(OP_GXFR_WPR_DR, 2'h3, 2'h0, 8'h00);
      idle_wait();
      xfer(OP_RD_DR, 2'h3, 2'h1, 8'h00);
      chk(rd, 8'h11);
      xfer(OP_XFR_WPR_DR, 2'h1, 2'h1, 8'h00);
      idle_wait();
      xfer(OP_RD_DR, 2'h1, 2'h1, 8'h00);
      chk(rd, 8'h11);
      xfer(OP_XFR_DR_WPR, 2'h0, 2'h1, 8'h00);
      chk({2'h0, wpos_s[1]}, NV_INIT);
   endtask

   task automatic t_incdec;
      logic [7:0] exp [4] = '{8'h3f, 8'h3f, 8'h00, 8'h00};
      int         i;
      for (i = 0; i < 4; i++) begin
         if (i % 2 == 0) xfer(OP_WR_WPR, 2'h0, 2'h0, i == 0 ? 8'h3e : 8'h01);
         xfer(i < 2 ? OP_INC : OP_DEC, 2'h0, 2'h0, 8'h00);
         chk({2'h0, wpos_s[0]}, exp[i]);
      end
   endtask

   task automatic t_step;
      stepit(1'b1);
      chk({2'h0, wpos_t[0]}, 8'h21);
      stepit(1'b0);
      stepit(1'b0);
      chk({2'h0, wpos_t[0]}, 8'h1f);
      repeat (40) stepit(1'b1);
      chk({2'h0, wpos_t[0]}, 8'h3f);
      chk({7'h0, tap_t[0] === 64'h8000_0000_0000_0000}, 8'h01);
      chk({6'h0, link_t.sel_n, link_t.step}, 8'h03);
   endtask

   // ---------------------------------------------------------------
   // Clock, timeout and main sequence
   // ---------------------------------------------------------------
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         $display("MISMATCH %0t run did not finish", $time);
         end_sim();
      end
   end

   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_recall();
      t_wiper();
      t_busy();
      t_xfer();
      t_incdec();
      t_step();
      end_sim();
   end
endmodule // dpwc_bench

`default_nettype wire
